// *** logic/exec_alu.v ***
// Result and zero detection for the five operations that produce a result
`timescale 1ns/1ps
`include "exec_defs.vh"

module exec_alu #(
	parameter DATA_W = 8
) (
	input wire [`OP_W-1:0] op, // Operation select
	input wire [DATA_W-1:0] acc, // Working accumulator
	input wire [DATA_W-1:0] fdata, // Addressed file register value
	input wire [DATA_W-1:0] lit, // Eight-bit immediate
	output reg [DATA_W-1:0] result, // Operation result
	output wire res_zero // Result is all zeros
);

	////////////////////////////////////////////////////////////////////////
	// Arithmetic and logic per operation; wraps at the data width
	always @* begin
		case (op)
			`OP_DEC_SKIP: result = fdata - {{(DATA_W-1){1'b0}}, 1'b1};
			`OP_INC_SKIP: result = fdata + {{(DATA_W-1){1'b0}}, 1'b1};
			`OP_INC_FILE: result = fdata + {{(DATA_W-1){1'b0}}, 1'b1};
			`OP_OR_LIT: result = acc | lit;
			`OP_OR_FILE: result = acc | fdata;
			default: result = {DATA_W{1'b0}};
		endcase
	end

	// Zero test over the full result width
	assign res_zero = (result == {DATA_W{1'b0}});

endmodule

// *** logic/exec_defs.vh ***
// Constants for the skip, jump and OR execution block
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// Operation select codes presented with each issued instruction
`define OP_W 3
`define OP_NOP 3'h0
`define OP_DEC_SKIP 3'h1
`define OP_INC_SKIP 3'h2
`define OP_JUMP 3'h3
`define OP_OR_LIT 3'h4
`define OP_INC_FILE 3'h5
`define OP_OR_FILE 3'h6

// Destination bit values
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1

// Field positions
`define JUMP_IMM_HI 10
`define LATCH_JUMP_HI 4
`define LATCH_JUMP_LO 3
`define PTR_W 13
`define FADDR_W 7

// Reset values
`define ACC_RST 8'h00
`define ZERO_RST 1'b0
`define PTR_RST 13'h0000

// Slot counts: a skipped or jump instruction costs one extra slot
`define EXTRA_SLOTS 1

`endif

// *** logic/skip_jump_or_logic_exec.v ***
// Execution stage for skip-on-null, absolute jump, OR and increment
`timescale 1ns/1ps
`include "exec_defs.vh"

// Summary of operation
// - Destination bit 0 writes accumulator, 1 writes file register at address 0..127
// - Decrement-skip subtracts one, routes by destination, leaves flags alone
// - Decrement-skip zero result discards next instruction as a nop, two cycles
// - Increment-skip adds one, routes result, no flags, skips on zero result
// - Jump loads 11-bit immediate into pointer 10:0, latch bits 4:3 into 12:11
// - Jump takes two cycles and changes no flag
// - OR-literal ORs eight-bit immediate into accumulator and updates zero flag
// - Plain increment adds one, routes by destination, updates zero, never skips
// - OR-with-file ORs accumulator with file register, routes result, updates zero
module skip_jump_or_logic_exec #(
	parameter DATA_W = 8,
	parameter IMM_W = 11
) (
	input wire mclk, // Core instruction clock
	input wire rst_n, // Asynchronous reset, active low
	input wire op_valid, // Instruction issued this cycle
	input wire [`OP_W-1:0] op_sel, // Operation select code
	input wire dest_bit, // Destination: 0 accumulator, 1 file register
	input wire [`FADDR_W-1:0] file_addr, // Addressed file register
	input wire [DATA_W-1:0] file_rdata, // Current value of that file register
	input wire [IMM_W-1:0] imm, // Immediate operand (literal in low bits)
	input wire [DATA_W-1:0] upper_jump_latch, // Upper jump latch register
	output reg [DATA_W-1:0] acc_q, // Working accumulator
	output reg zero_q, // Zero flag
	output reg file_we_q, // File register write strobe
	output reg [`FADDR_W-1:0] file_waddr_q, // File register write address
	output reg [DATA_W-1:0] file_wdata_q, // File register write data
	output reg ptr_load_q, // Instruction pointer load strobe
	output reg [`PTR_W-1:0] ptr_q, // New instruction pointer value
	output reg squash_q, // Current slot is a forced nop
	output reg done_q // An instruction completed execution
);

	localparam S_RUN = 1'b0;
	localparam S_FLUSH = 1'b1;

	reg state_q;
	reg state_d;
	reg [DATA_W-1:0] acc_d;
	reg zero_d;
	reg file_we_d;
	reg [DATA_W-1:0] file_wdata_d;
	reg ptr_load_d;
	reg [`PTR_W-1:0] ptr_d;
	reg squash_d;
	reg done_d;
	wire take;
	wire [DATA_W-1:0] alu_result;
	wire alu_zero;
	wire op_jump;
	wire op_or_lit;
	wire skip_hit;

	////////////////////////////////////////////////////////////////////////
	// Operation decode shared by routing and flag logic
	function writes_dest;
		input [`OP_W-1:0] op;
		begin
			writes_dest = (op == `OP_DEC_SKIP) || (op == `OP_INC_SKIP) ||
				(op == `OP_INC_FILE) || (op == `OP_OR_FILE);
		end
	endfunction

	function is_skip;
		input [`OP_W-1:0] op;
		begin
			is_skip = (op == `OP_DEC_SKIP) || (op == `OP_INC_SKIP);
		end
	endfunction

	function sets_zero;
		input [`OP_W-1:0] op;
		begin
			sets_zero = (op == `OP_OR_LIT) || (op == `OP_INC_FILE) ||
				(op == `OP_OR_FILE);
		end
	endfunction

	// An instruction arriving in a flush slot is the discarded one
	assign take = op_valid && (state_q == S_RUN);

	// Single decodes; skip_hit waits on the ALU so it stays combinational
	assign op_jump = (op_sel == `OP_JUMP);
	assign op_or_lit = (op_sel == `OP_OR_LIT);
	assign skip_hit = is_skip(op_sel) && alu_zero;

	////////////////////////////////////////////////////////////////////////
	// Shared arithmetic
	exec_alu #(
		.DATA_W(DATA_W)
	) u_alu (
		.op(op_sel),
		.acc(acc_q),
		.fdata(file_rdata),
		.lit(imm[DATA_W-1:0]),
		.result(alu_result),
		.res_zero(alu_zero)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state, result routing and flag update
	always @* begin
		state_d = S_RUN;
		acc_d = acc_q;
		zero_d = zero_q;
		file_we_d = 1'b0;
		file_wdata_d = file_wdata_q;
		ptr_load_d = 1'b0;
		ptr_d = ptr_q;
		squash_d = 1'b0;
		done_d = 1'b0;
		case (state_q)
			S_RUN: begin
				if (take) begin
					done_d = 1'b1;
					// Route by destination bit
					if (writes_dest(op_sel)) begin
						if (dest_bit == `DEST_FILE) begin
							file_we_d = 1'b1;
							file_wdata_d = alu_result;
						end else begin
							acc_d = alu_result;
						end
					end
					// Literal OR always lands in the accumulator
					if (op_or_lit) begin
						acc_d = alu_result;
					end
					// Skip ops leave the flag untouched
					if (sets_zero(op_sel)) begin
						zero_d = alu_zero;
					end
					// Zero result on a skip op turns the next slot into a nop
					if (skip_hit) begin
						state_d = S_FLUSH;
					end
					// Jump: new pointer now, prefetched slot flushed next
					if (op_jump) begin
						ptr_load_d = 1'b1;
						ptr_d = {upper_jump_latch[`LATCH_JUMP_HI:`LATCH_JUMP_LO],
							imm[`JUMP_IMM_HI:0]};
						state_d = S_FLUSH;
					end
				end
			end
			S_FLUSH: begin
				// Forced nop: any issued instruction is dropped
				// Only one slot is dropped, so a skip offered here cannot chain
				squash_d = 1'b1;
				state_d = S_RUN;
			end
			default: begin
				state_d = S_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: a taken skip or jump spends exactly one flush slot
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Accumulator kept here, so the register file never sees its traffic
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= `ACC_RST;
		end else begin
			acc_q <= acc_d;
		end
	end

	// Zero flag; skip and jump ops leave it as it was
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			zero_q <= `ZERO_RST;
		end else begin
			zero_q <= zero_d;
		end
	end

	// File write port; address follows the taken op so write and address match
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			file_we_q <= 1'b0;
			file_waddr_q <= {`FADDR_W{1'b0}};
			file_wdata_q <= `ACC_RST;
		end else begin
			file_we_q <= file_we_d;
			if (take) begin
				file_waddr_q <= file_addr;
			end
			file_wdata_q <= file_wdata_d;
		end
	end

	// Jump target held after the strobe, so fetch may pick it up late
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_load_q <= 1'b0;
			ptr_q <= `PTR_RST;
		end else begin
			ptr_load_q <= ptr_load_d;
			ptr_q <= ptr_d;
		end
	end

	// One-cycle strobes for the fetch stage
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			squash_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			squash_q <= squash_d;
			done_q <= done_d;
		end
	end

endmodule

// *** testbench/exec_chk_sva.sv ***
// Port checks for the execution stage
`timescale 1ns/1ps
module exec_chk (
	input wire mclk, // Clock
	input wire rst_n, // Reset
	input wire op_valid, // Issue
	input wire [2:0] op_sel, // Op
	input wire dest_bit, // Dest
	input wire [7:0] file_rdata, // Operand
	input wire [10:0] imm, // Immediate
	input wire [7:0] upper_jump_latch, // Latch
	input wire [7:0] acc_q, // Acc
	input wire zero_q, // Zero
	input wire file_we_q, // Write
	input wire [7:0] file_wdata_q, // Wdata
	input wire ptr_load_q, // Load
	input wire [12:0] ptr_q, // Target
	input wire squash_q, // Nop slot
	input wire done_q // Done
);
////////////////////////////////////////
// Discarded slot, since it decides which ops are taken
reg fl_q;
wire t = op_valid && !fl_q;
always @(posedge mclk or negedge rst_n)
	if (!rst_n) fl_q <= 1'b0;
	else fl_q <= t && (op_sel == 3'h3 || (op_sel == 3'h1 && file_rdata == 8'h01)
		|| (op_sel == 3'h2 && file_rdata == 8'hff));
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
chk_jump_target: assert property (t && op_sel == 3'h3 |=>
	ptr_load_q && ptr_q == {$past(upper_jump_latch[4:3]), $past(imm)}) else $error("jump");
chk_jump_flags: assert property (t && op_sel == 3'h3 |=>
	$stable(zero_q) && $stable(acc_q)) else $error("jump flags");
chk_null_squash: assert property (fl_q |=> squash_q) else $error("squash");
chk_null_done: assert property (fl_q |=> !done_q) else $error("done");
chk_dec_write: assert property (t && op_sel == 3'h1 && dest_bit |=>
	file_we_q && file_wdata_q == $past(file_rdata) - 8'h01 && $stable(zero_q)) else $error("dec");
chk_inc_acc: assert property (t && op_sel == 3'h5 && !dest_bit |=>
	acc_q == $past(file_rdata) + 8'h01 && zero_q == !acc_q && !file_we_q) else $error("inc");
chk_or_lit: assert property (t && op_sel == 3'h4 |=>
	acc_q == ($past(acc_q) | $past(imm[7:0])) && zero_q == !acc_q) else $error("or lit");
chk_or_file: assert property (t && op_sel == 3'h6 && dest_bit |=>
	file_we_q && file_wdata_q == ($past(acc_q) | $past(file_rdata)) && $stable(acc_q))
	else $error("or file");
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the execution stage
`timescale 1ns/1ps
module tb_top;
reg mclk = 0, rst_n = 0, op_valid = 0, dest_bit = 0, zero_m = 0, w;
reg [2:0] op_sel = 0;
reg [6:0] file_addr = 0;
reg [7:0] file_rdata = 0, upper_jump_latch = 0, acc_m = 0, r;
reg [10:0] imm = 0;
integer seed = 32'h9b4573a2, failures = 0, compares = 0, cyc = 0, i;
wire [7:0] acc_q, file_wdata_q;
wire [6:0] file_waddr_q;
wire [12:0] ptr_q;
wire zero_q, file_we_q, ptr_load_q, squash_q, done_q;
skip_jump_or_logic_exec uut (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_sel(op_sel),
	.dest_bit(dest_bit), .file_addr(file_addr), .file_rdata(file_rdata), .imm(imm),
	.upper_jump_latch(upper_jump_latch), .acc_q(acc_q), .zero_q(zero_q),
	.file_we_q(file_we_q), .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q),
	.ptr_load_q(ptr_load_q), .ptr_q(ptr_q), .squash_q(squash_q), .done_q(done_q));
always #20 mclk = ~mclk;
////////////////////////////////////////
task chk(input [12:0] s, input [12:0] e);
	begin
		compares = compares + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("[ERR] %0t seen %h want %h", $time, s, e);
		end
	end
endtask
task close_out;
	begin
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
endtask
// Expected result, worked from the bench's own accumulator
function [7:0] res(input [2:0] op);
	case (op)
		3'h1: res = file_rdata - 8'h01;
		3'h2, 3'h5: res = file_rdata + 8'h01;
		3'h4: res = acc_m | imm[7:0];
		default: res = acc_m | file_rdata;
	endcase
endfunction
// Issue one op, check it, then offer an op in any flush slot
task go(input [2:0] op, input d, input [7:0] fr, input [10:0] im);
	begin
		@(negedge mclk);
		op_valid = 1;
		op_sel = op;
		dest_bit = d;
		file_rdata = fr;
		imm = im;
		file_addr = $random(seed);
		upper_jump_latch = $random(seed);
		r = res(op);
		w = d && op inside {3'h1, 3'h2, 3'h5, 3'h6};
		if (op == 3'h4 || (!d && op inside {3'h1, 3'h2, 3'h5, 3'h6})) acc_m = r;
		if (op inside {3'h4, 3'h5, 3'h6}) zero_m = (r == 8'h00);
		@(negedge mclk);
		op_valid = 0;
		chk(acc_q, acc_m);
		chk(done_q, 1);
		chk(file_waddr_q, file_addr);
		chk(zero_q, zero_m);
		chk(file_we_q, w);
		if (w) chk(file_wdata_q, r);
		chk(ptr_load_q, op == 3'h3);
		if (op == 3'h3) chk(ptr_q, {upper_jump_latch[4:3], im});
		if (op == 3'h3 || ((op == 3'h1 || op == 3'h2) && r == 8'h00)) begin
			// Offered in the flush slot, so it must be thrown away
			op_valid = 1;
			op_sel = 3'h4;
			imm = 11'h0ff;
			@(negedge mclk);
			op_valid = 0;
			chk(done_q, 0);
			chk(acc_q, acc_m);
			chk(zero_q, zero_m);
			chk(file_we_q, 0);
			chk(squash_q, 1);
		end else
			chk(squash_q, 0);
	end
endtask
// Hang guard
always @(posedge mclk) begin
	cyc = cyc + 1;
	if (cyc == 5000) begin
		failures = failures + 1;
		close_out;
	end
end
initial begin
	repeat (10) @(negedge mclk);
	rst_n = 1;
	go(3'h1, 1, 8'h01, 0);
	go(3'h2, 0, 8'hff, 0);
	go(3'h3, 0, 0, 11'h7ff);
	go(3'h4, 0, 0, 0);
	go(3'h5, 1, 8'hff, 0);
	go(3'h6, 0, 0, 0);
	for (i = 0; i < 300; i = i + 1)
		go($random(seed), $random(seed), $random(seed), $random(seed));
	close_out;
end
endmodule
bind skip_jump_or_logic_exec exec_chk chk (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid),
	.op_sel(op_sel), .dest_bit(dest_bit), .file_rdata(file_rdata), .imm(imm),
	.upper_jump_latch(upper_jump_latch), .acc_q(acc_q), .zero_q(zero_q),
	.file_we_q(file_we_q), .file_wdata_q(file_wdata_q), .ptr_load_q(ptr_load_q),
	.ptr_q(ptr_q), .squash_q(squash_q), .done_q(done_q));
